// ==== src/seek_sense_pkg.sv ====
// Purpose: shared constants for the positioning and temperature-sense command pair
// Assumes: one clock, task-file registers carried as plain 8-bit words
// Notes: field positions follow the task-file layout of the drive

package seek_sense_pkg;
    // ----------------------------------------------------------------
    // opcodes and parameters
    // ----------------------------------------------------------------
    localparam logic [3:0] POSITION_NIBBLE = 4'h7;
    localparam logic [7:0] POSITION_OPCODE = 8'h70;
    localparam logic [7:0] SENSE_OPCODE = 8'hf0;
    localparam logic [7:0] SENSE_FEATURE = 8'h01;
    // ----------------------------------------------------------------
    // device/head fields
    // ----------------------------------------------------------------
    localparam int INDEX_MODE_BIT = 6;
    localparam int HEAD_LSB = 0;
    localparam int HEAD_W = 4;
    // ----------------------------------------------------------------
    // fault_cause bits
    // ----------------------------------------------------------------
    localparam int TARGET_MISSING_BIT = 4;
    localparam int COMMAND_REJECTED_BIT = 2;
    // ----------------------------------------------------------------
    // drive_condition bits
    // ----------------------------------------------------------------
    localparam int WORKING_BIT = 7;
    localparam int READY_BIT = 6;
    localparam int UNIT_FAULT_BIT = 5;
    localparam int POSITIONING_DONE_BIT = 4;
    localparam int ERROR_SUMMARY_BIT = 0;
    localparam logic [7:0] CONDITION_RESET = 8'h50;
    // ----------------------------------------------------------------
    // temperature coding, in half degrees above -20 C
    // ----------------------------------------------------------------
    localparam logic [7:0] TEMP_LOW_CODE = 8'h00;
    localparam logic [7:0] TEMP_HIGH_CODE = 8'hff;
    localparam int TEMP_MIN_C = -20;
    localparam int TEMP_MAX_C = 107;
    // ----------------------------------------------------------------
    // host command port registers
    // ----------------------------------------------------------------
    localparam logic [3:0] HOST_CTRL = 4'h0;
    localparam logic [3:0] HOST_ADDR = 4'h1;
    localparam logic [3:0] HOST_RESULT = 4'h2;
    localparam logic [3:0] HOST_FAULT = 4'h3;
    localparam logic [3:0] HOST_IRQ_STATUS = 4'h4;
    localparam logic [3:0] HOST_IRQ_MASK = 4'h5;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_SENSE_BIT = 1;
    localparam int CTRL_LINEAR_BIT = 2;
    localparam int CTRL_FEATURE_LSB = 8;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ERROR_BIT = 1;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLOCK_MHZ = 250;
    localparam int SEEK_TIME_NS = 400;
    localparam int SEEK_CYCLES = (SEEK_TIME_NS * CLOCK_MHZ + 999) / 1000;
endpackage : seek_sense_pkg

// ==== src/task_file_if.sv ====
// Purpose: task-file carrier between host controller and drive
// Assumes: single clock, host writes command last
// Notes: command_strobe is one cycle; done pulses once per command

`timescale 1ns/1ns
`default_nettype none

interface task_file_if;
    logic [7:0] command_parameter;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] cylinder_low;
    logic [7:0] cylinder_high;
    logic [7:0] unit_and_track_surface;
    logic [7:0] opcode_entry;
    logic command_strobe;
    logic [7:0] result_count;
    logic [7:0] result_number;
    logic [7:0] result_cyl_low;
    logic [7:0] result_cyl_high;
    logic [7:0] result_head;
    logic [7:0] fault_cause;
    logic [7:0] drive_condition;
    logic done;

    modport host (
        output command_parameter, sector_count, sector_number, cylinder_low,
        output cylinder_high, unit_and_track_surface, opcode_entry, command_strobe,
        input result_count, result_number, result_cyl_low, result_cyl_high,
        input result_head, fault_cause, drive_condition, done
    );
    modport device (
        input command_parameter, sector_count, sector_number, cylinder_low,
        input cylinder_high, unit_and_track_surface, opcode_entry, command_strobe,
        output result_count, result_number, result_cyl_low, result_cyl_high,
        output result_head, fault_cause, drive_condition, done
    );
endinterface : task_file_if

`default_nettype wire

// ==== src/drive_cmd_unit.sv ====
// Purpose: drive-side interpreter for the positioning and temperature-sense commands
// Assumes: temperature sample given in half degrees above -20 C, signed 10 bits
// Notes: seek movement is modelled by a fixed settle time; no medium needed
//
// What this block does
// - opcodes 70h..7Fh all mean positioning
// - positioning moves to track and head, unformatted ok
// - cylinder registers give the seek cylinder
// - head field is head or linear bits 24-27
// - linear address spread over four registers
// - report current linear address after a linear seek; cylinder and head after a cylinder/head seek
// - F0h is the temperature-sense opcode
// - host loads feature 01h before sensing
// - other feature value rejects sense command
// - sense works while in standby
// - temperature code returned in sector count
// - code 00h at or below -20 C
// - code = (temp + 20) * 2 within range
// - code FFh above 107 C
//
// Design decisions made here: the address-and-strobe port and the address map.

`timescale 1ns/1ns
`default_nettype none

module drive_cmd_unit
    import seek_sense_pkg::*;
#(
    parameter int SETTLE_CYCLES = SEEK_CYCLES,
    parameter logic [15:0] MAX_CYLINDER = 16'hffff,
    parameter logic [27:0] MAX_LINEAR = 28'hfffffff
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic enable_i,
    // drive environment
    input wire logic signed [9:0] temp_half_c_i,
    input wire logic standby_i,
    // task file
    task_file_if.device tf
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, SEEKING, FINISH} phase_t;

    typedef struct packed {
        phase_t phase;
        logic [15:0] count;
        logic [15:0] cylinder;
        logic [3:0] head;
        logic [27:0] linear;
        logic linear_mode;
        // where the heads rest now; kept as it was when a seek misses
        logic [27:0] reported;
        logic [7:0] count_out;
        logic [7:0] fault;
        logic [7:0] cond;
        logic done;
    } state_t;

    state_t cur;
    state_t next_cur;

    // temperature in half degrees above -20 C maps straight to the code
    function automatic logic [7:0] temp_code(input logic signed [9:0] half);
        if (half <= 10'sd0) begin
            temp_code = TEMP_LOW_CODE;
        end else if (half > 10'(2 * (TEMP_MAX_C - TEMP_MIN_C))) begin
            temp_code = TEMP_HIGH_CODE;
        end else begin
            temp_code = half[7:0];
        end
    endfunction : temp_code

    // a target past the last block or cylinder cannot be found on the medium
    function automatic logic out_of_range(input logic lin, input logic [27:0] lba,
                                          input logic [15:0] cyl);
        if (lin) begin
            out_of_range = (lba > MAX_LINEAR);
        end else begin
            out_of_range = (cyl > MAX_CYLINDER);
        end
    endfunction : out_of_range

    // the address the heads rest on, in the layout the host reads back;
    // the sector byte means nothing for a cylinder/head seek and reads zero
    function automatic logic [27:0] rest_address(input logic lin, input logic [27:0] lba,
                                                 input logic [15:0] cyl,
                                                 input logic [3:0] hd);
        if (lin) begin
            rest_address = lba;
        end else begin
            rest_address = {hd, cyl, 8'h00};
        end
    endfunction : rest_address

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    logic is_position;
    logic is_sense;
    logic feature_ok;
    logic linear_req;
    logic [3:0] head_req;
    logic [15:0] cylinder_req;
    logic [27:0] linear_req_addr;

    // only the upper nibble is compared, so 70h..7Fh all mean positioning
    // targets are sampled on the strobe edge only; the host may move on after it
    assign is_position = (tf.opcode_entry[7:4] == POSITION_NIBBLE);
    assign is_sense = (tf.opcode_entry == SENSE_OPCODE);
    assign feature_ok = (tf.command_parameter == SENSE_FEATURE);
    assign linear_req = tf.unit_and_track_surface[INDEX_MODE_BIT];
    assign head_req = tf.unit_and_track_surface[HEAD_LSB +: HEAD_W];
    assign cylinder_req = {tf.cylinder_high, tf.cylinder_low};
    assign linear_req_addr = {head_req, tf.cylinder_high, tf.cylinder_low,
                              tf.sector_number};

    // ----------------------------------------------------------------
    // command sequencing
    // ----------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        case (cur.phase)
            IDLE: begin
                if (tf.command_strobe) begin
                    next_cur.fault = 8'h00;
                    next_cur.cond[ERROR_SUMMARY_BIT] = 1'b0;
                    next_cur.cond[WORKING_BIT] = 1'b1;
                    if (is_position) begin
                        next_cur.linear_mode = linear_req;
                        next_cur.cylinder = cylinder_req;
                        next_cur.head = head_req;
                        next_cur.linear = linear_req_addr;
                        next_cur.cond[POSITIONING_DONE_BIT] = 1'b0;
                        next_cur.count = '0;
                        next_cur.phase = SEEKING;
                    end else if (is_sense) begin
                        // standby does not block sensing: no spin-up needed
                        if (!feature_ok) begin
                            next_cur.fault[COMMAND_REJECTED_BIT] = 1'b1;
                            next_cur.cond[ERROR_SUMMARY_BIT] = 1'b1;
                        end else begin
                            next_cur.count_out = temp_code(temp_half_c_i);
                        end
                        next_cur.phase = FINISH;
                    end else begin
                        next_cur.fault[COMMAND_REJECTED_BIT] = 1'b1;
                        next_cur.cond[ERROR_SUMMARY_BIT] = 1'b1;
                        next_cur.phase = FINISH;
                    end
                end
            end
            SEEKING: begin
                next_cur.count = cur.count + 16'h0001;
                // settling is a fixed time, so an unformatted medium seeks as well
                if (32'(cur.count) + 1 >= SETTLE_CYCLES) begin
                    if (out_of_range(cur.linear_mode, cur.linear, cur.cylinder)) begin
                        next_cur.fault[TARGET_MISSING_BIT] = 1'b1;
                        next_cur.cond[ERROR_SUMMARY_BIT] = 1'b1;
                    end else begin
                        next_cur.cond[POSITIONING_DONE_BIT] = 1'b1;
                        next_cur.reported = rest_address(cur.linear_mode, cur.linear,
                                                         cur.cylinder, cur.head);
                    end
                    next_cur.phase = FINISH;
                end
            end
            FINISH: begin
                // working drops with done, so done never meets a busy drive
                next_cur.cond[WORKING_BIT] = 1'b0;
                next_cur.done = 1'b1;
                next_cur.phase = IDLE;
            end
            default: begin
                next_cur.phase = IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register: a low enable freezes every field
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur <= '{phase: IDLE, count: 16'h0000, cylinder: 16'h0000, head: 4'h0,
                     linear: 28'h0000000, linear_mode: 1'b0, reported: 28'h0000000,
                     count_out: 8'h00, fault: 8'h00, cond: CONDITION_RESET, done: 1'b0};
        end else if (enable_i) begin
            cur <= next_cur;
        end
    end

    // ----------------------------------------------------------------
    // task-file answers
    // ----------------------------------------------------------------
    // every answer comes straight from a register, so the host sees no glitches
    assign tf.result_count = cur.count_out;
    assign tf.result_number = cur.reported[7:0];
    assign tf.result_cyl_low = cur.reported[15:8];
    assign tf.result_cyl_high = cur.reported[23:16];
    assign tf.result_head = {4'h0, cur.reported[27:24]};
    assign tf.fault_cause = cur.fault;
    assign tf.drive_condition = cur.cond;
    assign tf.done = cur.done;
endmodule : drive_cmd_unit

`default_nettype wire

// ==== src/host_cmd_unit.sv ====
// Purpose: host-side controller issuing positioning and temperature-sense commands
// Assumes: software port with one-cycle read latency
// Notes: ignores new go while a command is outstanding

`timescale 1ns/1ns
`default_nettype none

module host_cmd_unit
    import seek_sense_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic enable_i,
    // software port
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    // task file
    task_file_if.host tf
);
    typedef struct packed {
        logic busy;
        logic [15:0] ctrl;
        logic [27:0] addr;
        logic [7:0] cmd;
        logic strobe;
        logic [31:0] rdata;
        logic [1:0] status;
        logic [1:0] mask;
        logic irq;
    } host_t;

    host_t cur;
    host_t next_cur;

    always_comb begin
        next_cur = cur;
        next_cur.strobe = 1'b0;
        next_cur.rdata = 32'h00000000;
        if (enable_i && write_i) begin
            case (addr_i)
                HOST_CTRL: begin
                    if (wdata_i[CTRL_GO_BIT] && !cur.busy) begin
                        next_cur.ctrl = wdata_i[15:0];
                        // sense uses F0h and feature from ctrl (01h expected)
                        next_cur.cmd = wdata_i[CTRL_SENSE_BIT] ? SENSE_OPCODE
                                                               : POSITION_OPCODE;
                        next_cur.strobe = 1'b1;
                        next_cur.busy = 1'b1;
                    end
                end
                HOST_ADDR: next_cur.addr = wdata_i[27:0];
                HOST_IRQ_STATUS: next_cur.status = cur.status & ~wdata_i[1:0];
                HOST_IRQ_MASK: next_cur.mask = wdata_i[1:0];
                default: begin
                end
            endcase
        end
        if (tf.done) begin
            next_cur.busy = 1'b0;
            next_cur.status[IRQ_DONE_BIT] = 1'b1;
            if (tf.drive_condition[ERROR_SUMMARY_BIT]) begin
                next_cur.status[IRQ_ERROR_BIT] = 1'b1;
            end
        end
        if (enable_i && read_i) begin
            case (addr_i)
                HOST_CTRL: next_cur.rdata = {15'h0000, cur.busy, cur.ctrl};
                HOST_ADDR: next_cur.rdata = {4'h0, tf.result_head[3:0], tf.result_cyl_high,
                                             tf.result_cyl_low, tf.result_number};
                HOST_RESULT: next_cur.rdata = {24'h000000, tf.result_count};
                HOST_FAULT: next_cur.rdata = {16'h0000, tf.drive_condition, tf.fault_cause};
                HOST_IRQ_STATUS: next_cur.rdata = {30'h0, cur.status};
                HOST_IRQ_MASK: next_cur.rdata = {30'h0, cur.mask};
                default: next_cur.rdata = 32'h00000000;
            endcase
        end
        next_cur.irq = |(next_cur.status & next_cur.mask);
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cur <= '0;
        end else if (enable_i) begin
            cur <= next_cur;
        end
    end

    assign rdata_o = cur.rdata;
    assign irq_o = cur.irq;
    assign tf.opcode_entry = cur.cmd;
    assign tf.command_strobe = cur.strobe;
    assign tf.command_parameter = cur.ctrl[CTRL_FEATURE_LSB +: 8];
    assign tf.sector_count = 8'h00;
    assign tf.sector_number = cur.addr[7:0];
    assign tf.cylinder_low = cur.addr[15:8];
    assign tf.cylinder_high = cur.addr[23:16];
    assign tf.unit_and_track_surface = {1'b1, cur.ctrl[CTRL_LINEAR_BIT], 2'b10,
                                        cur.addr[27:24]};
endmodule : host_cmd_unit

`default_nettype wire

// ==== tb/seek_sense_props.sv ====
// Purpose: timing and result checks on the task-file carrier
// Assumes: one clock; targets captured when a command is taken
// Notes: value checks look one cycle after done, where results stand
`timescale 1ns/1ns
`default_nettype none
module seek_sense_props
    import seek_sense_pkg::*;
#(
    parameter int SETTLE_CYCLES = SEEK_CYCLES
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic nrst_i,
    // host side
    input wire logic [7:0] command_parameter,
    input wire logic [7:0] sector_number,
    input wire logic [7:0] cylinder_low,
    input wire logic [7:0] cylinder_high,
    input wire logic [7:0] unit_and_track_surface,
    input wire logic [7:0] opcode_entry,
    input wire logic command_strobe,
    // device side
    input wire logic [7:0] result_count,
    input wire logic [7:0] result_number,
    input wire logic [7:0] result_cyl_low,
    input wire logic [7:0] result_cyl_high,
    input wire logic [7:0] result_head,
    input wire logic [7:0] fault_cause,
    input wire logic [7:0] drive_condition,
    input wire logic done
);
    localparam int SEEK_AT = SETTLE_CYCLES + 2;
    logic take;
    logic sense;
    logic [27:0] tgt;
    logic lin;
    logic seek;
    assign take = command_strobe && !drive_condition[WORKING_BIT];
    assign sense = take && (opcode_entry == SENSE_OPCODE);
    // a strobe while working is ignored, so only taken commands are captured
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tgt <= '0;
            lin <= 1'b0;
            seek <= 1'b0;
        end else if (take) begin
            tgt <= {unit_and_track_surface[3:0], cylinder_high, cylinder_low, sector_number};
            lin <= unit_and_track_surface[INDEX_MODE_BIT];
            seek <= (opcode_entry[7:4] == POSITION_NIBBLE);
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    AST_WORKING_SET: assert property (take |=> drive_condition[WORKING_BIT])
        else $error("working not raised after command");
    AST_SENSE_DONE: assert property (sense |-> ##2 done)
        else $error("sense command not finished in two cycles");
    AST_SENSE_REJECT: assert property (sense && command_parameter != SENSE_FEATURE |-> ##3
        fault_cause[COMMAND_REJECTED_BIT] && drive_condition[ERROR_SUMMARY_BIT]
        && result_count == $past(result_count, 3))
        else $error("bad feature not rejected");
    AST_SENSE_ACCEPT: assert property (sense && command_parameter == SENSE_FEATURE |-> ##3
        !fault_cause[COMMAND_REJECTED_BIT] && !drive_condition[ERROR_SUMMARY_BIT])
        else $error("valid sense command flagged");
    AST_SEEK_DONE: assert property (take && opcode_entry[7:4] == POSITION_NIBBLE
        |-> ##SEEK_AT done)
        else $error("positioning not finished after settle time");
    AST_LINEAR_REPORT: assert property (done && seek && lin |=> drive_condition[0]
        || {result_head[3:0], result_cyl_high, result_cyl_low, result_number} == tgt)
        else $error("reported linear address differs");
    AST_CHS_REPORT: assert property (done && seek && !lin |=> drive_condition[0]
        || {result_head[3:0], result_cyl_high, result_cyl_low} == tgt[27:8])
        else $error("reported cylinder or head differs");
    AST_DONE_CLEARS: assert property (done |-> !drive_condition[WORKING_BIT] ##1 !done)
        else $error("working held at done or done too long");
    AST_ERR_SUMMARY: assert property (done |=> drive_condition[ERROR_SUMMARY_BIT]
        == (fault_cause[TARGET_MISSING_BIT] | fault_cause[COMMAND_REJECTED_BIT]))
        else $error("error summary disagrees with fault bits");
endmodule : seek_sense_props
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: both ends joined, driven through the host software port
// Assumes: settle time shortened to 2, linear limit lowered to test misses
// Notes: status is polled rather than waited on, so a hang is bounded
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import seek_sense_pkg::*;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic write_i = 1'b0;
    logic read_i = 1'b0;
    logic [31:0] rdata_o;
    logic irq_o;
    logic signed [9:0] temp_half_c_i = 10'h000;
    logic standby_i = 1'b0;
    int err_total = 0;
    int samples_checked = 0;
    task_file_if tf ();
    host_cmd_unit u_host_cmd_unit (.clock_i(clock_i), .nrst_i(nrst_i), .enable_i(1'b1),
        .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
        .rdata_o(rdata_o), .irq_o(irq_o), .tf(tf));
    drive_cmd_unit #(.SETTLE_CYCLES(2), .MAX_LINEAR(28'h0ffffff)) u_drive_cmd_unit (
        .clock_i(clock_i), .nrst_i(nrst_i), .enable_i(1'b1), .temp_half_c_i(temp_half_c_i),
        .standby_i(standby_i), .tf(tf));
    seek_sense_props #(.SETTLE_CYCLES(2)) u_seek_sense_props (.clock_i(clock_i),
        .nrst_i(nrst_i), .command_parameter(tf.command_parameter),
        .sector_number(tf.sector_number), .cylinder_low(tf.cylinder_low),
        .cylinder_high(tf.cylinder_high), .unit_and_track_surface(tf.unit_and_track_surface),
        .opcode_entry(tf.opcode_entry), .command_strobe(tf.command_strobe),
        .result_count(tf.result_count), .result_number(tf.result_number),
        .result_cyl_low(tf.result_cyl_low), .result_cyl_high(tf.result_cyl_high),
        .result_head(tf.result_head), .fault_cause(tf.fault_cause),
        .drive_condition(tf.drive_condition), .done(tf.done));
    initial begin
        forever #2 clock_i = ~clock_i;
    end
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clock_i);
        write_i <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clock_i);
        read_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // clears old events first so the returned status belongs to this command
    task go(input logic [31:0] ctrl, output logic [31:0] st);
        int n;
        wr(HOST_IRQ_STATUS, 32'h3);
        wr(HOST_CTRL, ctrl);
        for (n = 0; n < 40; n++) begin
            rd(HOST_IRQ_STATUS, st);
            if (st[1:0] != 2'h0) break;
        end
        if (n == 40) check(32'h0, 32'h1, "command never finished");
    endtask : go
    task automatic sense_codes();
        logic [9:0] t [0:6] = '{10'h3fc, 10'h000, 10'h001, 10'h055, 10'h0fe, 10'h0ff, 10'h190};
        logic [7:0] c [0:6] = '{8'h00, 8'h00, 8'h01, 8'h55, 8'hfe, 8'hff, 8'hff};
        logic [31:0] st;
        logic [31:0] d;
        standby_i <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            @(posedge clock_i);
            temp_half_c_i <= t[i];
            go(32'h0103, st);
            check(st[1:0], 32'h1, "sense status");
            check(irq_o, 32'h0, "masked irq");
            rd(HOST_RESULT, d);
            check(d[7:0], c[i], "temperature code");
        end
    endtask : sense_codes
    task sense_reject();
        logic [31:0] st;
        logic [31:0] d;
        wr(HOST_IRQ_MASK, 32'h3);
        go(32'h0203, st);
        check(st[1], 32'h1, "reject event");
        check(irq_o, 32'h1, "unmasked irq");
        rd(HOST_FAULT, d);
        check({d[15], d[8], d[4], d[2]}, 32'h5, "reject flags");
        rd(HOST_RESULT, d);
        check(d[7:0], 32'hff, "count kept");
        wr(HOST_IRQ_STATUS, 32'h3);
        @(posedge clock_i);
        #1 check(irq_o, 32'h0, "irq cleared");
    endtask : sense_reject
    task seek_cases();
        logic [31:0] st;
        logic [31:0] d;
        wr(HOST_ADDR, 32'h0ffffff);
        go(32'h5, st);
        check(st[1:0], 32'h1, "linear seek at limit");
        check({tf.unit_and_track_surface[6], tf.unit_and_track_surface[3:0], tf.cylinder_high,
            tf.cylinder_low, tf.sector_number}, {1'b1, 28'h0ffffff}, "linear wire");
        check(tf.opcode_entry[7:4], 32'h7, "seek opcode");
        rd(HOST_ADDR, d);
        check(d[27:0], 32'h0ffffff, "current address");
        wr(HOST_ADDR, 32'h1000000);
        go(32'h5, st);
        check(st[1], 32'h1, "miss event");
        rd(HOST_FAULT, d);
        check({d[15], d[8], d[4], d[2]}, 32'h6, "miss flags");
        wr(HOST_ADDR, 32'h3001234);
        go(32'h1, st);
        check(st[1:0], 32'h1, "head and cylinder seek");
        check(tf.unit_and_track_surface[6], 32'h0, "mode bit");
        rd(HOST_ADDR, d);
        check(d[27:0], 32'h3001200, "cylinder and head report");
    endtask : seek_cases
    task complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    initial begin
        repeat (16) @(posedge clock_i);
        nrst_i <= 1'b1;
        sense_codes();
        sense_reject();
        seek_cases();
        complete_run();
    end
    initial begin
        #40000;
        err_total++;
        $display("wrong value at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
